/* File: hw/rot_window.sv */
// main-window rotation and address setup registers with display fetch address walker
`timescale 1ns/1ps
module rot_window
	import rot_window_pkg::*;
(
	// clock and reset
	input  wire logic                                  mclk,
	input  wire logic                                  rst_b,
	// wishbone classic slave
	input  wire logic                                  wb_cyc_i,
	input  wire logic                                  wb_stb_i,
	input  wire logic                                  wb_we_i,
	input  wire logic [rot_window_pkg::ADR_W-1:0]      wb_adr_i,
	input  wire logic [3:0]                            wb_sel_i,
	input  wire logic [rot_window_pkg::DAT_W-1:0]      wb_dat_i,
	output logic      [rot_window_pkg::DAT_W-1:0]      wb_dat_o,
	output logic                                       wb_ack_o,
	// display timing strobes
	input  wire logic                                  frame_start,
	input  wire logic                                  line_start,
	input  wire logic                                  dword_step,
	// configuration seen by the display pipeline
	output logic      [1:0]                            rotation_select,
	output logic                                       byte_swap,
	output logic                                       word_swap,
	output logic                                       sub_window_enable,
	// display buffer fetch address
	output logic      [rot_window_pkg::START_W-1:0]    fetch_addr
);
	import rot_window_pkg::*;

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [7:0]          effects_r;
	logic [START_W-1:0]  start_r;
	logic [OFFSET_W-1:0] offset_r;
	logic [START_W-1:0]  fetch_r;
	logic [START_W-1:0]  line_base_r;
	logic [DAT_W-1:0]    rdata_r;
	logic                ack_r;
	logic [7:0]          idx;
	logic                wr_go;
	rotation_t           rot;

	// the low two address bits are ignored, so any byte of a dword reaches the same register
	assign idx   = wb_adr_i[ADR_W-1:2];
	// a write lands only on the edge at which the master sees ack high
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
	assign rot   = rotation_t'(effects_r[ROT_LSB +: 2]);

	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	// ack comes one cycle after the request and drops the cycle after
	// a master that keeps cyc and stb up therefore sees one ack every second cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
		end
	end

	// read data is captured with the request so it is stable under ack
	// the fetch bytes are a snapshot of that edge, so a walk in progress can tear them
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= '0;
		end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
			case (idx)
				IDX_SPECIAL_EFFECTS: rdata_r <= {24'h000000, effects_r};
				IDX_START_LOW:       rdata_r <= {24'h000000, start_r[7:0]};
				IDX_START_MID:       rdata_r <= {24'h000000, start_r[15:8]};
				IDX_START_HIGH:      rdata_r <= {31'h00000000, start_r[16]};
				IDX_OFFSET_LOW:      rdata_r <= {24'h000000, offset_r[7:0]};
				IDX_OFFSET_HIGH:     rdata_r <= {30'h00000000, offset_r[9:8]};
				IDX_FETCH_LOW:       rdata_r <= {24'h000000, fetch_r[7:0]};
				IDX_FETCH_MID:       rdata_r <= {24'h000000, fetch_r[15:8]};
				IDX_FETCH_HIGH:      rdata_r <= {31'h00000000, fetch_r[16]};
				default:             rdata_r <= '0; // unmapped reads as zero
			endcase
		end
	end

	// ------------------------------------------------------------
	// software-written configuration
	// ------------------------------------------------------------
	// special effects: rotation, swaps and sub-window enable; n/a bits stay zero
	// writes to the unused bits are dropped, so they always read back as zero
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			effects_r <= SPECIAL_EFFECTS_RESET;
		end else if (wr_go && idx == IDX_SPECIAL_EFFECTS) begin
			effects_r <= wb_dat_i[7:0] & SPECIAL_EFFECTS_MASK;
		end
	end

	// start address, one byte lane per register
	// each byte lands at once; change all three between frames to avoid a torn start
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			start_r <= START_RESET;
		end else if (wr_go) begin
			case (idx)
				IDX_START_LOW:  start_r[7:0]  <= wb_dat_i[7:0];
				IDX_START_MID:  start_r[15:8] <= wb_dat_i[7:0];
				IDX_START_HIGH: start_r[16]   <= wb_dat_i[0];
				default:        start_r       <= start_r;
			endcase
		end
	end

	// line offset, ten bits over two registers
	// a new offset takes effect from the next line strobe on, or from the next dword step at ROT_90 and ROT_270
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			offset_r <= OFFSET_RESET;
		end else if (wr_go) begin
			case (idx)
				IDX_OFFSET_LOW:  offset_r[7:0] <= wb_dat_i[7:0];
				IDX_OFFSET_HIGH: offset_r[9:8] <= wb_dat_i[1:0];
				default:         offset_r      <= offset_r;
			endcase
		end
	end

	// ------------------------------------------------------------
	// fetch address walker
	// ------------------------------------------------------------
	// steps are whole dwords, so the walk is the same at every colour depth;
	// pixel unpacking within a dword belongs to the pixel pipeline
	// registers are not shadowed: a new start is taken at the next frame strobe
	// all sums wrap modulo the 17-bit dword space of the buffer
	logic [START_W-1:0] offset_ext;
	logic [START_W-1:0] step_nxt;
	logic [START_W-1:0] line_nxt;

	assign offset_ext = {{(START_W-OFFSET_W){1'b0}}, offset_r};

	// counter-clockwise rotation picks direction along and across memory lines
	// the default arm only keeps the logic closed; a two-bit select never reaches it
	always_comb begin
		step_nxt = fetch_r;
		line_nxt = line_base_r;
		case (rot)
			ROT_0: begin
				step_nxt = fetch_r + 17'h00001;
				line_nxt = line_base_r + offset_ext;
			end
			ROT_90: begin
				step_nxt = fetch_r + offset_ext;
				line_nxt = line_base_r - 17'h00001;
			end
			ROT_180: begin
				step_nxt = fetch_r - 17'h00001;
				line_nxt = line_base_r - offset_ext;
			end
			ROT_270: begin
				step_nxt = fetch_r - offset_ext;
				line_nxt = line_base_r + 17'h00001;
			end
			default: begin
				step_nxt = fetch_r;
				line_nxt = line_base_r;
			end
		endcase
	end

	// frame start wins over line start, which wins over a dword step
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fetch_r <= START_RESET;
		end else if (frame_start) begin
			fetch_r <= start_r;
		end else if (line_start) begin
			fetch_r <= line_nxt;
		end else if (dword_step) begin
			fetch_r <= step_nxt;
		end
	end

	// the line base moves only on frame and line strobes, with the same priority
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			line_base_r <= START_RESET;
		end else if (frame_start) begin
			line_base_r <= start_r;
		end else if (line_start) begin
			line_base_r <= line_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs, all from flip-flops
	// ------------------------------------------------------------
	assign wb_dat_o          = rdata_r;
	assign wb_ack_o          = ack_r;
	assign rotation_select   = effects_r[ROT_LSB +: 2];
	assign byte_swap         = effects_r[BYTE_SWAP_BIT];
	assign word_swap         = effects_r[WORD_SWAP_BIT];
	assign sub_window_enable = effects_r[SUB_ENABLE_BIT];
	assign fetch_addr        = fetch_r;

endmodule : rot_window

/* File: hw/rot_window_pkg.sv */
// constants shared by the rotated main-window address block
package rot_window_pkg;

	// ------------------------------------------------------------
	// register indices (byte address on the bus is four times these)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_SPECIAL_EFFECTS = 8'h71;
	localparam logic [7:0] IDX_START_LOW       = 8'h74;
	localparam logic [7:0] IDX_START_MID       = 8'h75;
	localparam logic [7:0] IDX_START_HIGH      = 8'h76;
	localparam logic [7:0] IDX_OFFSET_LOW      = 8'h78;
	localparam logic [7:0] IDX_OFFSET_HIGH     = 8'h79;
	localparam logic [7:0] IDX_FETCH_LOW       = 8'h60;
	localparam logic [7:0] IDX_FETCH_MID       = 8'h61;
	localparam logic [7:0] IDX_FETCH_HIGH      = 8'h62;

	// ------------------------------------------------------------
	// field layout and widths
	// ------------------------------------------------------------
	localparam int START_W          = 17;
	localparam int OFFSET_W         = 10;
	localparam int ADR_W            = 10;
	localparam int DAT_W            = 32;
	localparam int ROT_LSB          = 0;
	localparam int SUB_ENABLE_BIT   = 4;
	localparam int BYTE_SWAP_BIT    = 6;
	localparam int WORD_SWAP_BIT    = 7;
	localparam logic [7:0] SPECIAL_EFFECTS_MASK = 8'hd3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]          SPECIAL_EFFECTS_RESET = 8'h00;
	localparam logic [START_W-1:0]  START_RESET           = 17'h00000;
	localparam logic [OFFSET_W-1:0] OFFSET_RESET          = 10'h000;

	// rotation select codes, counter-clockwise steps of ninety degrees
	typedef enum logic [1:0] {
		ROT_0   = 2'b00,
		ROT_90  = 2'b01,
		ROT_180 = 2'b10,
		ROT_270 = 2'b11
	} rotation_t;

endpackage : rot_window_pkg

/* File: testbench/rot_window_assertions.sv */
// port assertions for the rotated main-window block
`timescale 1ns/1ps
module rot_window_assertions (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_b,
	// bus side
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [9:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// display timing strobes
	input wire logic        frame_start,
	input wire logic        line_start,
	input wire logic        dword_step,
	// configuration and fetch outputs
	input wire logic [1:0]  rotation_select,
	input wire logic        byte_swap,
	input wire logic        word_swap,
	input wire logic        sub_window_enable,
	input wire logic [16:0] fetch_addr
);
	import rot_window_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// a lone step has no frame or line strobe beside it, since those would win
	sequence s_step; dword_step && !frame_start && !line_start; endsequence
	sequence s_rot_wr; wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h1c4; endsequence
	wire rd = wb_ack_o && !wb_we_i;
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	AST_ROT_WR: assert property (s_rot_wr |=> rotation_select == $past(wb_dat_i) % 4) else $error("rot write");
	AST_FX_RD: assert property (rd && wb_adr_i == 10'h1c4 |->
		wb_dat_o == {word_swap, byte_swap, 1'h0, sub_window_enable, 2'h0, rotation_select}) else $error("fx read");
	AST_UNMAP: assert property (rd && wb_adr_i[9:2] == 8'h77 |-> wb_dat_o == 32'h0) else $error("unmapped");
	AST_STEP0: assert property (s_step ##0 rotation_select == ROT_0 |=> fetch_addr == $past(fetch_addr) + 17'h1)
		else $error("step at 0");
	AST_STEP180: assert property (s_step ##0 rotation_select == ROT_180 |=> fetch_addr == $past(fetch_addr) - 17'h1)
		else $error("step at 180");
	AST_HOLD: assert property (!frame_start && !line_start && !dword_step |=> $stable(fetch_addr)) else $error("drift");
endmodule : rot_window_assertions
bind rot_window rot_window_assertions chk (.*);

/* File: testbench/rot_window_host.sv */
// host software model: works out the main-window setup and runs wishbone cycles
`timescale 1ns/1ps
module rot_window_host (
	// clock
	input  wire logic        mclk,
	// wishbone classic master
	output logic             wb_cyc_i,
	output logic             wb_stb_i,
	output logic             wb_we_i,
	output logic [9:0]       wb_adr_i,
	output logic [3:0]       wb_sel_i,
	output logic [31:0]      wb_dat_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o
);
	initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
	// one classic cycle: the request stands until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d, input logic s, output logic [31:0] q);
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, w, 3'h0, s};
		wb_adr_i <= {i, 2'h0};
		wb_dat_i <= d;
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		wb_dat_i <= ~d; // a released bus keeps no stale value
	endtask : xfer
	// start dword per rotation; integer division drops the fraction
	function automatic logic [16:0] start_of(input logic [1:0] r, input int ba, w, h, bpp);
		case (r)
			2'h0: return 17'(ba / 4);
			2'h1: return 17'((ba + h * bpp / 8) / 4 - 1);
			2'h2: return 17'((ba + w * h * bpp / 8) / 4 - 1);
			default: return 17'((ba + (w - 1) * h * bpp / 8) / 4);
		endcase
	endfunction : start_of
	// rounding up turns an unaligned width into a wider virtual line
	task automatic setup(input logic [7:0] e, input int ba, w, h, bpp, output logic [16:0] st, output logic [9:0] of);
		logic [31:0] q;
		st = start_of(e[1:0], ba, w, h, bpp);
		of = 10'(((e[0] ? h : w) * bpp + 31) / 32);
		xfer(1'b1, 8'h71, 32'(e), 1'b1, q);
		xfer(1'b1, 8'h74, 32'(st[7:0]), 1'b1, q);
		xfer(1'b1, 8'h75, 32'(st[15:8]), 1'b1, q);
		xfer(1'b1, 8'h76, 32'(st[16]), 1'b1, q);
		xfer(1'b1, 8'h78, 32'(of[7:0]), 1'b1, q);
		xfer(1'b1, 8'h79, 32'(of[9:8]), 1'b1, q);
	endtask : setup
endmodule : rot_window_host

/* File: testbench/rot_window_test.sv */
// self-checking bench: random setups, register readback and fetch walks
`timescale 1ns/1ps
module rot_window_test;
	logic        mclk, rst_b, frame_start, line_start, dword_step, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        byte_swap, word_swap, sub_window_enable;
	logic [1:0]  rotation_select;
	logic [3:0]  wb_sel_i;
	logic [9:0]  wb_adr_i, of;
	logic [16:0] fetch_addr, st, fa, base, d;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [7:0]  e, ex [6];
	logic [7:0]  idx [6] = '{8'h71, 8'h74, 8'h75, 8'h76, 8'h78, 8'h79};
	logic [2:0]  pat [7] = '{3'h4, 3'h1, 3'h1, 3'h2, 3'h1, 3'h3, 3'h7};
	int          errors, n_tests, cycles, bpp, seed = 32'hd60476a6;
	rot_window dut (.*);
	rot_window_host host (.*);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	// one strobe cycle against the reference walker; fetch is read after the edge lands
	task automatic walk(input logic [2:0] s);
		@(posedge mclk);
		{frame_start, line_start, dword_step} <= s;
		@(posedge mclk);
		{frame_start, line_start, dword_step} <= 3'h0;
		#1;
		d = (e[0] ^ s[1]) ? 17'(of) : 17'h1;
		if (s[1] ? ^e[1:0] : e[1]) d = -d;
		if (s[2]) base = st;
		else if (s[1]) base = base + d;
		fa = (s[2] | s[1]) ? base : fa + d;
		check("fetch", 32'(fetch_addr), 32'(fa));
	endtask : walk
	// the run needs about 1250 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		{rst_b, frame_start, line_start, dword_step} = 4'h0;
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		foreach (idx[i]) begin
			host.xfer(1'b0, idx[i], 32'h0, 1'b1, q);
			check("reset", q, 32'h0);
		end
		// refused writes: an unmapped index, and sel[0] low
		host.xfer(1'b1, 8'h77, 32'hff, 1'b1, q);
		host.xfer(1'b0, 8'h77, 32'h0, 1'b1, q);
		check("unmapped", q, 32'h0);
		host.xfer(1'b1, 8'h74, 32'h5a, 1'b0, q);
		host.xfer(1'b0, 8'h74, 32'h0, 1'b1, q);
		check("sel", q, 32'h0);
		// every rotation at every depth; the first four use a 320x240 panel at byte zero
		for (int k = 0; k < 20; k++) begin
			e = 8'($random(seed));
			e[1:0] = 2'(k);
			bpp = 1 << (k % 5);
			if (k < 4) host.setup(e, 0, 320, 240, bpp, st, of);
			else host.setup(e, {$random(seed)} % 65536, {$random(seed)} % 320 + 1, {$random(seed)} % 240 + 1, bpp, st, of);
			check("rot", 32'(rotation_select), 32'(e[1:0]));
			check("fx", 32'({word_swap, byte_swap, sub_window_enable}), 32'({e[7:6], e[4]}));
			ex = '{e & 8'hd3, st[7:0], st[15:8], {7'h0, st[16]}, of[7:0], {6'h0, of[9:8]}};
			foreach (idx[i]) begin
				host.xfer(1'b0, idx[i], 32'h0, 1'b1, q);
				check("reg", q, 32'(ex[i]));
			end
			foreach (pat[i]) walk(pat[i]);
			host.xfer(1'b0, 8'h60, 32'h0, 1'b1, q);
			check("fetch_low", q, 32'(fa[7:0]));
			host.xfer(1'b0, 8'h61, 32'h0, 1'b1, q);
			check("fetch_mid", q, 32'(fa[15:8]));
			host.xfer(1'b0, 8'h62, 32'h0, 1'b1, q);
			check("fetch_high", q, 32'(fa[16]));
		end
		// reset in mid-run: outputs and registers fall back to zero
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		check("rst_cfg", 32'({rotation_select, byte_swap, word_swap, sub_window_enable, wb_ack_o}), 32'h0);
		check("rst_fetch", 32'(fetch_addr), 32'h0);
		foreach (idx[i]) begin
			host.xfer(1'b0, idx[i], 32'h0, 1'b1, q);
			check("rst_reg", q, 32'h0);
		end
		summarize();
	end
endmodule : rot_window_test
